// [hw/uscr_pkg.sv]
// Constants and types of the UART shadow control block
`default_nettype none
package uscr_pkg;
  // ---------------------------------------------------------------
  // Bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_QCR  = 32'h5000_1008;
  localparam logic [ADDR_W-1:0] ADDR_LCR  = 32'h5000_100C;
  localparam logic [ADDR_W-1:0] ADDR_MCR  = 32'h5000_1010;
  localparam logic [ADDR_W-1:0] ADDR_BRK  = 32'h5000_1090;
  localparam logic [ADDR_W-1:0] ADDR_DMAM = 32'h5000_1094;
  localparam logic [ADDR_W-1:0] ADDR_QEN  = 32'h5000_1098;
  localparam logic [ADDR_W-1:0] ADDR_RXT  = 32'h5000_109C;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 32'h5000_10B0;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 32'h5000_10B4;
  localparam logic [DATA_W-1:0] RD_ZERO   = 16'h0000;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LCR_BREAK_BIT = 6;
  localparam int MCR_LOOP_BIT  = 4;
  localparam int MCR_IR_BIT    = 6;
  localparam int QCR_EN_BIT    = 0;
  localparam int QCR_DMA_BIT   = 3;
  localparam int QCR_RXT_LO    = 6;
  localparam int QCR_RXT_HI    = 7;
  // Bits 1 and 2 are self-clearing resets and are not held
  localparam logic [CTRL_W-1:0] QCR_WR_MASK = 8'hF9;
  localparam logic [CTRL_W-1:0] CTRL_RST    = 8'h00;
  localparam logic              LINE_MARK   = 1'b1;
  localparam logic              LINE_SPACE  = 1'b0;
  localparam logic              DMA_MODE0   = 1'b0;
  localparam logic              DMA_MODE1   = 1'b1;
  typedef enum logic [1:0] {
    RXT_ONE      = 2'h0,
    RXT_QUARTER  = 2'h1,
    RXT_HALF     = 2'h2,
    RXT_TWO_LESS = 2'h3
  } uscr_rxt_type;
  // ---------------------------------------------------------------
  // Events and timing
  // ---------------------------------------------------------------
  localparam int EVT_RX_TRIG = 0;
  localparam int EVT_QRESET  = 1;
  localparam int EVT_NUM     = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int IR_PULSE_NS   = 1600;
  localparam int IR_PULSE_CYC  = (IR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_DEPTH_DEF  = 16;
  localparam int TX_DEPTH_DEF  = 16;
endpackage
`default_nettype wire

// [hw/uscr_top.sv]
// UART shadow control registers: break, DMA mode, queue enable, rx trigger
// How it works
// - The break alias reads and writes bit 6 of the line control register.
// - Break without loopback holds the serial output low until cleared.
// - Break in infrared mode without loopback pulses the infrared output continuously.
// - Break in loopback goes back to the own receiver, not to the pin.
// - The DMA mode alias reads and writes bit 3 of the queue control register.
// - DMA mode 0 or 1 selects the signalling of both DMA request outputs.
// - The queue enable alias reads and writes bit 0 of the queue control register.
// - Queue enable switches both queues, and clearing it resets them.
// - The rx trigger alias reads and writes bits 7:6 of the queue control register.
// - With queues enabled, the rx trigger picks the fill level that raises data available.
// - In DMA mode 1 the receive request follows the same trigger level.
// - An alias write changes only its own field of the parent register.
`default_nettype none
module uscr_top #(
  parameter int RX_DEPTH        = uscr_pkg::RX_DEPTH_DEF,
  parameter int TX_DEPTH        = uscr_pkg::TX_DEPTH_DEF,
  parameter int IR_PULSE_CYCLES = uscr_pkg::IR_PULSE_CYC,
  parameter int LW              = $clog2(uscr_pkg::RX_DEPTH_DEF + 1)
) (
  input  wire logic                        CLOCK,
  input  wire logic                        RST_N,
  input  wire logic [uscr_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [uscr_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [uscr_pkg::DATA_W-1:0] RDATA,
  input  wire logic                        TX_SERIAL_IN,
  input  wire logic                        IR_SERIAL_IN_N,
  input  wire logic                        RXD,
  output logic                             TXD,
  output logic                             IR_OUT_N,
  output logic                             RX_SERIAL_OUT,
  input  wire logic [LW-1:0]               RX_LEVEL,
  input  wire logic [LW-1:0]               TX_LEVEL,
  output logic                             QUEUE_ENABLE,
  output logic                             QUEUE_RESET,
  output logic                             RX_DATA_AVAIL,
  output logic                             DMA_TX_REQ_N,
  output logic                             DMA_RX_REQ_N,
  output logic                             IRQ
);
  import uscr_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int IR_CNT_W = (IR_PULSE_CYCLES > 1) ? $clog2(IR_PULSE_CYCLES) : 1;
  localparam logic [IR_CNT_W-1:0] IR_LAST  = IR_CNT_W'(IR_PULSE_CYCLES - 1);
  localparam logic [IR_CNT_W-1:0] IR_ZERO  = '0;
  localparam logic [LW-1:0]       LVL_ZERO = '0;
  localparam logic [LW-1:0]       THR_ONE  = LW'(1);
  localparam logic [LW-1:0]       THR_QTR  = LW'(RX_DEPTH / 4);
  localparam logic [LW-1:0]       THR_HALF = LW'(RX_DEPTH / 2);
  localparam logic [LW-1:0]       THR_TWO  = LW'(RX_DEPTH - 2);
  localparam logic [LW-1:0]       TX_FULL  = LW'(TX_DEPTH);

  logic [CTRL_W-1:0]  lcr_ff;
  logic [CTRL_W-1:0]  mcr_ff;
  logic [CTRL_W-1:0]  qcr_ff;
  logic [EVT_NUM-1:0] stat_ff;
  logic [EVT_NUM-1:0] mask_ff;
  logic [EVT_NUM-1:0] evt;
  logic [DATA_W-1:0]  rdata_ff;
  logic [DATA_W-1:0]  nxt_rdata;
  logic               wr_lcr;
  logic               wr_mcr;
  logic               wr_qcr;
  logic               wr_brk;
  logic               wr_dmam;
  logic               wr_qen;
  logic               wr_rxt;
  logic               wr_stat;
  logic               wr_mask;
  logic               brk;
  logic               loop;
  logic               ir_mode;
  logic               q_en;
  logic               dma_mode;
  uscr_rxt_type       rxt;
  logic               q_en_d_ff;
  logic               qreset_ff;
  logic               txd_ff;
  logic               ir_out_n_ff;
  logic               rx_loop_ff;
  logic [IR_CNT_W-1:0] ir_cnt_ff;
  logic               ir_phase_ff;
  logic               ir_brk;
  logic               ir_tick;
  logic [LW-1:0]      rx_thr;
  logic               rx_hit;
  logic               rx_hit_d_ff;
  logic               rx_avail_ff;
  logic               rx_req_ff;
  logic               tx_req_ff;
  logic               nxt_rx_req;
  logic               nxt_tx_req;
  logic               rx_empty;
  logic               tx_empty;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign wr_lcr  = WR && (ADDR == ADDR_LCR);
  assign wr_mcr  = WR && (ADDR == ADDR_MCR);
  assign wr_qcr  = WR && (ADDR == ADDR_QCR);
  assign wr_brk  = WR && (ADDR == ADDR_BRK);
  assign wr_dmam = WR && (ADDR == ADDR_DMAM);
  assign wr_qen  = WR && (ADDR == ADDR_QEN);
  assign wr_rxt  = WR && (ADDR == ADDR_RXT);
  assign wr_stat = WR && (ADDR == ADDR_STAT);
  assign wr_mask = WR && (ADDR == ADDR_MASK);

  assign brk      = lcr_ff[LCR_BREAK_BIT];
  assign loop     = mcr_ff[MCR_LOOP_BIT];
  assign ir_mode  = mcr_ff[MCR_IR_BIT];
  assign q_en     = qcr_ff[QCR_EN_BIT];
  assign dma_mode = qcr_ff[QCR_DMA_BIT];
  assign rxt      = uscr_rxt_type'(qcr_ff[QCR_RXT_HI:QCR_RXT_LO]);

  // ---------------------------------------------------------------
  // Control registers and their aliases
  // ---------------------------------------------------------------
  // Aliases touch one field only, so software needs no read-modify-write
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lcr_ff <= CTRL_RST;
    end else if (wr_lcr) begin
      lcr_ff <= WDATA[CTRL_W-1:0];
    end else if (wr_brk) begin
      lcr_ff[LCR_BREAK_BIT] <= WDATA[0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mcr_ff <= CTRL_RST;
    end else if (wr_mcr) begin
      mcr_ff <= WDATA[CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      qcr_ff <= CTRL_RST;
    end else if (wr_qcr) begin
      qcr_ff <= WDATA[CTRL_W-1:0] & QCR_WR_MASK;
    end else if (wr_dmam) begin
      qcr_ff[QCR_DMA_BIT] <= WDATA[0];
    end else if (wr_qen) begin
      qcr_ff[QCR_EN_BIT] <= WDATA[0];
    end else if (wr_rxt) begin
      qcr_ff[QCR_RXT_HI:QCR_RXT_LO] <= WDATA[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = RD_ZERO;
    case (ADDR)
      ADDR_LCR:  nxt_rdata[CTRL_W-1:0] = lcr_ff;
      ADDR_MCR:  nxt_rdata[CTRL_W-1:0] = mcr_ff;
      ADDR_QCR:  nxt_rdata[CTRL_W-1:0] = qcr_ff;
      ADDR_BRK:  nxt_rdata[0] = brk;
      ADDR_DMAM: nxt_rdata[0] = dma_mode;
      ADDR_QEN:  nxt_rdata[0] = q_en;
      ADDR_RXT:  nxt_rdata[1:0] = rxt;
      ADDR_STAT: nxt_rdata[EVT_NUM-1:0] = stat_ff;
      ADDR_MASK: nxt_rdata[EVT_NUM-1:0] = mask_ff;
      default:   nxt_rdata = RD_ZERO;
    endcase
  end

  // Data stands for the one cycle after the strobe only
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= RD_ZERO;
    end else if (RD) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= RD_ZERO;
    end
  end

  assign RDATA = rdata_ff;

  // ---------------------------------------------------------------
  // Serial line, break and loopback
  // ---------------------------------------------------------------
  // In loopback the pin idles at mark so the far end sees nothing
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      txd_ff     <= LINE_MARK;
      rx_loop_ff <= LINE_MARK;
    end else if (loop) begin
      txd_ff     <= LINE_MARK;
      rx_loop_ff <= brk ? LINE_SPACE : TX_SERIAL_IN;
    end else begin
      txd_ff     <= brk ? LINE_SPACE : TX_SERIAL_IN;
      rx_loop_ff <= RXD;
    end
  end

  assign TXD           = txd_ff;
  assign RX_SERIAL_OUT = rx_loop_ff;

  // ---------------------------------------------------------------
  // Infrared break pulses
  // ---------------------------------------------------------------
  assign ir_brk  = brk && ir_mode && !loop;
  assign ir_tick = (ir_cnt_ff == IR_LAST);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ir_cnt_ff <= IR_ZERO;
    end else if (!ir_brk || ir_tick) begin
      ir_cnt_ff <= IR_ZERO;
    end else begin
      ir_cnt_ff <= ir_cnt_ff + IR_CNT_W'(1);
    end
  end

  // Low and high for one divider period each, repeating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ir_phase_ff <= 1'b0;
    end else if (!ir_brk) begin
      ir_phase_ff <= 1'b0;
    end else if (ir_tick) begin
      ir_phase_ff <= !ir_phase_ff;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ir_out_n_ff <= LINE_MARK;
    end else if (loop) begin
      ir_out_n_ff <= LINE_MARK;
    end else if (ir_brk) begin
      ir_out_n_ff <= ir_phase_ff;
    end else begin
      ir_out_n_ff <= IR_SERIAL_IN_N;
    end
  end

  assign IR_OUT_N = ir_out_n_ff;

  // ---------------------------------------------------------------
  // Queue enable and reset
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q_en_d_ff <= 1'b0;
      qreset_ff <= 1'b0;
    end else begin
      q_en_d_ff <= q_en;
      qreset_ff <= q_en_d_ff && !q_en;
    end
  end

  assign QUEUE_ENABLE = q_en_d_ff;
  assign QUEUE_RESET  = qreset_ff;

  // ---------------------------------------------------------------
  // Receive trigger level
  // ---------------------------------------------------------------
  always_comb begin
    rx_thr = THR_ONE;
    case (rxt)
      RXT_ONE:      rx_thr = THR_ONE;
      RXT_QUARTER:  rx_thr = THR_QTR;
      RXT_HALF:     rx_thr = THR_HALF;
      RXT_TWO_LESS: rx_thr = THR_TWO;
      default:      rx_thr = THR_ONE;
    endcase
  end

  // Without queues a single held character is the trigger
  assign rx_empty = (RX_LEVEL == LVL_ZERO);
  assign tx_empty = (TX_LEVEL == LVL_ZERO);
  assign rx_hit   = q_en ? (RX_LEVEL >= rx_thr) : !rx_empty;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_avail_ff <= 1'b0;
      rx_hit_d_ff <= 1'b0;
    end else begin
      rx_avail_ff <= rx_hit;
      rx_hit_d_ff <= rx_hit;
    end
  end

  assign RX_DATA_AVAIL = rx_avail_ff;

  // ---------------------------------------------------------------
  // DMA requests
  // ---------------------------------------------------------------
  // Mode 1 holds a request from its threshold until the queue turns over
  always_comb begin
    nxt_rx_req = !rx_empty;
    nxt_tx_req = tx_empty;
    if (dma_mode == DMA_MODE1) begin
      nxt_rx_req = rx_hit ? 1'b1 : (rx_empty ? 1'b0 : rx_req_ff);
      nxt_tx_req = tx_empty ? 1'b1 : ((TX_LEVEL >= TX_FULL) ? 1'b0 : tx_req_ff);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_req_ff <= 1'b0;
      tx_req_ff <= 1'b0;
    end else begin
      rx_req_ff <= nxt_rx_req;
      tx_req_ff <= nxt_tx_req;
    end
  end

  assign DMA_RX_REQ_N = !rx_req_ff;
  assign DMA_TX_REQ_N = !tx_req_ff;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign evt[EVT_RX_TRIG] = rx_hit && !rx_hit_d_ff;
  assign evt[EVT_QRESET]  = qreset_ff;

  // A new event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < EVT_NUM; gi++) begin : g_stat
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          stat_ff[gi] <= 1'b0;
        end else if (evt[gi]) begin
          stat_ff[gi] <= 1'b1;
        end else if (wr_stat && WDATA[gi]) begin
          stat_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mask_ff <= '0;
    end else if (wr_mask) begin
      mask_ff <= WDATA[EVT_NUM-1:0];
    end
  end

  assign IRQ = |(stat_ff & mask_ff);

endmodule
`default_nettype wire

// [sim/uscr_assertions.sv]
// Checker of the UART shadow control block ports
`default_nettype none
module uscr_assertions
  import uscr_pkg::*;
#(
  parameter int RX_DEPTH        = 16,
  parameter int IR_PULSE_CYCLES = 80,
  parameter int LW              = 5
) (
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              TX_SERIAL_IN,
  input wire logic              TXD,
  input wire logic              IR_OUT_N,
  input wire logic              RX_SERIAL_OUT,
  input wire logic [LW-1:0]     RX_LEVEL,
  input wire logic [LW-1:0]     TX_LEVEL,
  input wire logic              QUEUE_ENABLE,
  input wire logic              QUEUE_RESET,
  input wire logic              RX_DATA_AVAIL,
  input wire logic              DMA_TX_REQ_N,
  input wire logic              DMA_RX_REQ_N
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Control bits as software last wrote them
  // ---------------------------------------------------------------
  logic       brk_ff, lp_ff, ir_ff, qen_ff, dma_ff, live_ff, irp_ff;
  logic [1:0] rxt_ff;
  logic [7:0] cnt_ff;
  int         thr;
  logic       hit, pulse;
  always_comb begin
    thr = (rxt_ff == 2'h0) ? 1 : (rxt_ff == 2'h1) ? RX_DEPTH / 4 :
          (rxt_ff == 2'h2) ? RX_DEPTH / 2 : RX_DEPTH - 2;
    hit = qen_ff ? (int'(RX_LEVEL) >= thr) : (RX_LEVEL != '0);
    pulse = brk_ff && ir_ff && !lp_ff;
  end
  // Outputs load one edge after reset release, so checks wait for it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {brk_ff, lp_ff, ir_ff, qen_ff, dma_ff, live_ff, irp_ff, rxt_ff} <= '0;
      cnt_ff <= 8'h00;
    end else begin
      live_ff <= 1'b1;
      irp_ff <= IR_OUT_N;
      cnt_ff <= (pulse && IR_OUT_N == irp_ff) ? cnt_ff + 8'h01 : 8'h00;
      if (WR) begin
        case (ADDR)
          ADDR_LCR:  brk_ff <= WDATA[LCR_BREAK_BIT];
          ADDR_BRK:  brk_ff <= WDATA[0];
          ADDR_MCR:  {ir_ff, lp_ff} <= {WDATA[MCR_IR_BIT], WDATA[MCR_LOOP_BIT]};
          ADDR_QCR:  {rxt_ff, dma_ff, qen_ff} <= {WDATA[7:6], WDATA[3], WDATA[0]};
          ADDR_DMAM: dma_ff <= WDATA[0];
          ADDR_QEN:  qen_ff <= WDATA[0];
          ADDR_RXT:  rxt_ff <= WDATA[1:0];
          default: ;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !live_ff);
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == RD_ZERO)
    else $error("read data not zero outside answer");
  AST_BRK_TXD: assert property (brk_ff && !lp_ff |=> !TXD)
    else $error("break did not hold txd low");
  AST_LOOP: assert property (lp_ff |=> TXD
    && RX_SERIAL_OUT == (!$past(brk_ff) && $past(TX_SERIAL_IN)))
    else $error("loopback path wrong");
  AST_IR_PULSE: assert property (cnt_ff <= 8'(IR_PULSE_CYCLES + 1))
    else $error("infrared output stopped pulsing");
  AST_QEN: assert property (QUEUE_ENABLE == $past(qen_ff))
    else $error("queue enable wrong");
  // Reset pulse and the falling enable both load from the same edge
  AST_QRST: assert property ($fell(QUEUE_ENABLE) |-> QUEUE_RESET ##1 !QUEUE_RESET)
    else $error("queue reset pulse missing");
  AST_QRST_CAUSE: assert property (QUEUE_RESET |-> $past(QUEUE_ENABLE) && !QUEUE_ENABLE)
    else $error("queue reset without disable");
  AST_AVAIL: assert property (RX_DATA_AVAIL == $past(hit))
    else $error("data available level wrong");
  AST_DMA0: assert property (!$past(dma_ff) |-> DMA_RX_REQ_N == ($past(RX_LEVEL) == '0)
    && DMA_TX_REQ_N == ($past(TX_LEVEL) != '0))
    else $error("mode 0 request wrong");
  AST_DMA1: assert property ($past(dma_ff) && $past(hit) |-> !DMA_RX_REQ_N)
    else $error("mode 1 receive request missing");
  COV_IR: cover property (pulse && $fell(IR_OUT_N));
  COV_QRST: cover property (QUEUE_RESET);
  COV_DMA1: cover property (dma_ff && !DMA_RX_REQ_N);
endmodule
`default_nettype wire

// [sim/uscr_partner.sv]
// Remote serial device on the transmit line
`default_nettype none
module uscr_partner (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic txd,
  input  wire logic talk,
  output logic      rxd,
  output int        brk_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_ff;
  // Line rests at mark; bursts change level freely every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_ff <= 8'h5A;
      rxd <= 1'b1;
      brk_len <= 0;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5]};
      rxd <= talk ? lfsr_ff[0] : 1'b1;
      brk_len <= txd ? 0 : brk_len + 1;
    end
  end
endmodule
`default_nettype wire

// [sim/uscr_top_tb.sv]
// Testbench of the UART shadow control block
`default_nettype none
module uscr_top_tb import uscr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 4;
  localparam int D = 16;
  logic              clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic              txi = 1'b1, iri = 1'b1, talk = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [4:0]        rxl = '0, txl = '0;
  logic              rxd, txd, irn, rso, qe, qr, av, dtx, drx, irq, rxd_q;
  int                errors = 0, checked = 0, seed = 52732, brk_len, qr_n = 0;
  int                m_lcr = 0, m_qcr = 0;
  logic [31:0]       amap[$] = '{ADDR_LCR, ADDR_QCR, ADDR_BRK, ADDR_DMAM, ADDR_QEN,
                                 ADDR_RXT, 32'h5000_10A0};
  always #10 clk = ~clk;
  always @(posedge clk) if (qr === 1'b1) qr_n++;
  // Far-end bit as the design sampled it at the last edge
  always @(posedge clk) rxd_q <= rxd;
  uscr_top #(.RX_DEPTH(D), .TX_DEPTH(D), .IR_PULSE_CYCLES(P), .LW(5)) u_dut (
    .CLOCK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TX_SERIAL_IN(txi), .IR_SERIAL_IN_N(iri), .RXD(rxd), .TXD(txd),
    .IR_OUT_N(irn), .RX_SERIAL_OUT(rso), .RX_LEVEL(rxl), .TX_LEVEL(txl),
    .QUEUE_ENABLE(qe), .QUEUE_RESET(qr), .RX_DATA_AVAIL(av), .DMA_TX_REQ_N(dtx),
    .DMA_RX_REQ_N(drx), .IRQ(irq));
  uscr_partner u_far (.clk(clk), .rst_n(rst_n), .txd(txd), .talk(talk), .rxd(rxd),
    .brk_len(brk_len));
  // ---------------------------------------------------------------
  // Bus tasks and reference model
  // ---------------------------------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (e !== g) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cb(string n, logic e, logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr16(logic [31:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(logic [31:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("read %h", a), e, rdata);
  endtask
  // Aliases and parents share one model word each
  task automatic put(logic [31:0] a, logic [15:0] d);
    case (a)
      ADDR_LCR:  m_lcr = d[7:0];
      ADDR_QCR:  m_qcr = d[7:0] & QCR_WR_MASK;
      ADDR_BRK:  m_lcr[6] = d[0];
      ADDR_DMAM: m_qcr[3] = d[0];
      ADDR_QEN:  m_qcr[0] = d[0];
      ADDR_RXT:  m_qcr[7:6] = d[1:0];
      default: ;
    endcase
    wr16(a, d);
  endtask
  function automatic logic [15:0] ev(logic [31:0] a);
    case (a)
      ADDR_LCR:  return 16'(m_lcr[7:0]);
      ADDR_QCR:  return 16'(m_qcr[7:0]);
      ADDR_BRK:  return 16'(m_lcr[6]);
      ADDR_DMAM: return 16'(m_qcr[3]);
      ADDR_QEN:  return 16'(m_qcr[0]);
      ADDR_RXT:  return 16'(m_qcr[7:6]);
      default:   return 16'h0000;
    endcase
  endfunction
  function automatic int thr(int t);
    return (t == 0) ? 1 : (t == 1) ? D / 4 : (t == 2) ? D / 2 : D - 2;
  endfunction
  task automatic lvl(int n);
    @(posedge clk);
    rxl <= 5'(n);
    cyc(2);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    errors++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] a;
    int          n;
    logic        prev;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (amap[i]) rdc(amap[i], 16'h0000);
    $display("test reset values done");
    repeat (24) begin
      a = amap[$unsigned($random(seed)) % 7];
      put(a, 16'($random(seed)));
      foreach (amap[j]) rdc(amap[j], ev(amap[j]));
    end
    put(ADDR_LCR, 16'h0000);
    put(ADDR_QCR, 16'h0000);
    $display("test alias access done");
    put(ADDR_BRK, 16'h0001);
    cyc(6);
    cb("txd break", 1'b0, txd);
    cb("remote break", 1'b1, brk_len >= 3);
    wr16(ADDR_MCR, 16'h0040);
    n = 0;
    repeat (40) begin
      prev = irn;
      cyc(1);
      n += (irn !== prev);
    end
    cb("ir pulse", 1'b1, n >= 8 && n <= 11);
    wr16(ADDR_MCR, 16'h0010);
    cyc(3);
    cb("txd loop", 1'b1, txd);
    cb("rx loop", 1'b0, rso);
    put(ADDR_BRK, 16'h0000);
    wr16(ADDR_MCR, 16'h0000);
    cyc(3);
    cb("txd idle", txi, txd);
    $display("test break done");
    put(ADDR_QEN, 16'h0001);
    put(ADDR_DMAM, 16'h0001);
    for (int t = 0; t < 4; t++) begin
      put(ADDR_RXT, 16'(t));
      lvl(0);
      lvl(thr(t) - 1);
      cb("avail below", 1'b0, av);
      cb("dma rx below", 1'b1, drx);
      lvl(thr(t));
      cb("avail at", 1'b1, av);
      cb("dma rx at", 1'b0, drx);
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      txl <= 5'((k == 0) ? D : (k == 2) ? 0 : 5);
      cyc(2);
      cb("dma tx mode 1", k < 2, dtx);
    end
    put(ADDR_QCR, 16'h0081);
    talk <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      rxl <= 5'($unsigned($random(seed)) % 17);
      txl <= 5'($unsigned($random(seed)) % 17);
      txi <= 1'($random(seed));
      iri <= 1'($random(seed));
      cyc(2);
      cb("dma rx mode 0", rxl == 5'h00, drx);
      cb("dma tx mode 0", txl != 5'h00, dtx);
      cb("avail half", int'(rxl) >= thr(2), av);
      cb("txd pass", txi, txd);
      cb("ir pass", iri, irn);
      cb("rx pass", rxd_q, rso);
    end
    lvl(0);
    $display("test trigger and dma done");
    wr16(ADDR_STAT, 16'h0003);
    rdc(ADDR_STAT, 16'h0000);
    wr16(ADDR_MASK, 16'h0002);
    rdc(ADDR_MASK, 16'h0002);
    n = qr_n;
    put(ADDR_QEN, 16'h0000);
    cyc(6);
    chk("queue reset pulses", 16'(n + 1), 16'(qr_n));
    cb("queue enable", 1'b0, qe);
    rdc(ADDR_STAT, 16'h0002);
    cb("irq raised", 1'b1, irq);
    wr16(ADDR_MASK, 16'h0000);
    cyc(1);
    cb("irq masked", 1'b0, irq);
    wr16(ADDR_MASK, 16'h0002);
    wr16(ADDR_STAT, 16'h0002);
    cyc(1);
    cb("irq cleared", 1'b0, irq);
    lvl(1);
    rdc(ADDR_STAT, 16'h0001);
    $display("test queue reset and interrupt done");
    wrap_up();
  end
endmodule
bind uscr_top uscr_assertions #(.RX_DEPTH(RX_DEPTH), .IR_PULSE_CYCLES(IR_PULSE_CYCLES),
  .LW(LW)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .TX_SERIAL_IN(TX_SERIAL_IN), .TXD(TXD), .IR_OUT_N(IR_OUT_N),
  .RX_SERIAL_OUT(RX_SERIAL_OUT), .RX_LEVEL(RX_LEVEL), .TX_LEVEL(TX_LEVEL),
  .QUEUE_ENABLE(QUEUE_ENABLE), .QUEUE_RESET(QUEUE_RESET), .RX_DATA_AVAIL(RX_DATA_AVAIL),
  .DMA_TX_REQ_N(DMA_TX_REQ_N), .DMA_RX_REQ_N(DMA_RX_REQ_N));
`default_nettype wire
